// >>> hw/usbp_pkg.sv
// constants and helpers shared by the shadow buffer port design
package usbp_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned ADDR_W = 32; // axi4-lite address width
  localparam int unsigned DATA_W = 32; // axi4-lite data width
  localparam int unsigned STRB_W = 4; // byte lanes
  localparam int unsigned BYTE_W = 8; // serial character width

  //////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [31:0] BUF_ADDR = 32'h5000_1154; // uart_shadow_rx_tx_buffer_9
  localparam logic [31:0] BUF_ALIAS_FIRST = 32'h5000_1130; // alias location 0
  localparam logic [31:0] BUF_ALIAS_LAST = 32'h5000_116c; // alias location 15
  localparam logic [31:0] LSW_ADDR = 32'h5000_1180; // line_status_word, read only
  localparam logic [31:0] FCW_ADDR = 32'h5000_1184; // fifo_control_word, read/write
  localparam logic [31:0] IRQ_STAT_ADDR = 32'h5000_1188; // sticky events, read only
  localparam logic [31:0] IRQ_CLR_ADDR = 32'h5000_118c; // write one to clear
  localparam logic [31:0] IRQ_EN_ADDR = 32'h5000_1190; // event enables

  //////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned LSW_AVL_BIT = 0; // rx_byte_available_flag
  localparam int unsigned LSW_OE_BIT = 1; // overrun, cleared by reading line status
  localparam int unsigned LSW_TXE_BIT = 5; // tx_holding_empty_flag
  localparam int unsigned FCW_FIFO_EN_BIT = 0; // fifo enable
  localparam int unsigned FCW_IR_BIT = 1; // infrared mode select
  localparam int unsigned FCW_W = 2; // implemented control bits
  localparam int unsigned IRQ_RX_BIT = 0; // byte became available
  localparam int unsigned IRQ_OE_BIT = 1; // overrun happened
  localparam int unsigned IRQ_TXE_BIT = 2; // transmit side went empty
  localparam int unsigned IRQ_W = 3; // number of events

  //////////////////////////////////////////////////////////////////////////////
  // reset values and sizes
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00; // data field after reset
  localparam logic [FCW_W-1:0] FCW_RST = 2'h0; // fifos off, uart mode
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0; // no events, none enabled
  localparam int unsigned FIFO_DEPTH = 16; // entries per fifo
  localparam int unsigned PTR_W = 4; // log2 of depth
  localparam int unsigned CNT_W = 5; // holds 0..depth
  localparam logic [1:0] RESP_OKAY = 2'h0; // axi okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // axi slave error

  // true for any of the sixteen aliased buffer locations
  function automatic logic is_buf_addr(input logic [ADDR_W-1:0] a);
    return (a >= BUF_ALIAS_FIRST) && (a <= BUF_ALIAS_LAST) && (a[1:0] == 2'h0);
  endfunction

endpackage

// >>> hw/usbp_fifo.sv
// sixteen-entry byte fifo with flush, used for both directions
module usbp_fifo
  import usbp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic flush,
  // write side
  input wire logic push,
  input wire logic [BYTE_W-1:0] push_data,
  // read side
  input wire logic pop,
  output logic [BYTE_W-1:0] head_data,
  // status
  output logic full,
  output logic empty
);

  logic [BYTE_W-1:0] mem_q [FIFO_DEPTH]; // storage array
  logic [PTR_W-1:0] wr_ptr_q; // next slot to fill
  logic [PTR_W-1:0] rd_ptr_q; // oldest slot
  logic [CNT_W-1:0] cnt_q; // occupancy

  // a push while full is dropped here so callers need no guard
  wire do_push = push && !full;
  wire do_pop = pop && !empty;

  assign full = (cnt_q == CNT_W'(FIFO_DEPTH));
  assign empty = (cnt_q == '0);
  assign head_data = mem_q[rd_ptr_q];

  // pointer and count bookkeeping
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) wr_ptr_q <= wr_ptr_q + PTR_W'(1);
      if (do_pop) rd_ptr_q <= rd_ptr_q + PTR_W'(1);
      cnt_q <= cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  // storage needs no reset, only valid entries are ever read
  always_ff @(posedge aclk) begin
    if (do_push) mem_q[wr_ptr_q] <= push_data;
  end

endmodule // usbp_fifo

// >>> hw/usbp_top.sv
// shadow receive/transmit buffer port with axi4-lite registers
//
// Summary of operation
// [RULE_01] sixteen aliased word locations reach one buffer
// [RULE_02] reads return received byte in bits 7:0
// [RULE_03] read byte valid only while data ready set
// [RULE_04] fifo off: new byte overwrites, flags overrun
// [RULE_05] fifo on: read pops oldest receive entry
// [RULE_06] receive fifo full: drop new byte, overrun
// [RULE_07] written byte queued for serial or infrared out
// [RULE_08] software writes only while transmit empty set
// [RULE_09] fifo off: write clears empty, rewrites overwrite
// [RULE_10] fifo on: sixteen writes accepted before full
// [RULE_11] writes to full transmit fifo are dropped
// [RULE_12] upper byte reads zero; data resets zero
//
// Local design decision: the AXI4-Lite interface to the registers.
module usbp_top
  import usbp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // received characters from the deframer
  input wire logic rx_valid,
  input wire logic [BYTE_W-1:0] rx_byte,
  // characters to the framer
  output logic tx_valid,
  output logic [BYTE_W-1:0] tx_byte,
  input wire logic tx_ready,
  // mode and line status to the framing logic
  output logic ir_mode,
  output logic fifo_enable,
  output logic rx_byte_available_flag,
  output logic tx_holding_empty_flag,
  output logic overrun,
  // interrupt
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // register bus front end
  logic wr_en; // one-cycle write strobe
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic wr_err; // unmapped write address
  logic rd_en; // one-cycle read strobe
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data; // combinational read mux
  logic rd_err; // unmapped read address

  usbp_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // address decode
  // protection bits carry no meaning for this block
  wire unused_prot = ^{s_axi_awprot, s_axi_arprot};
  wire wr_buf = wr_en && is_buf_addr(wr_addr) && wr_strb[0]; // RULE_01
  wire wr_fcw = wr_en && (wr_addr == FCW_ADDR) && wr_strb[0];
  wire wr_irq_clr = wr_en && (wr_addr == IRQ_CLR_ADDR) && wr_strb[0];
  wire wr_irq_en = wr_en && (wr_addr == IRQ_EN_ADDR) && wr_strb[0];
  wire rd_buf = rd_en && is_buf_addr(rd_addr); // RULE_01
  wire rd_lsw = rd_en && (rd_addr == LSW_ADDR);
  wire wr_hit = is_buf_addr(wr_addr) || (wr_addr == FCW_ADDR) || (wr_addr == IRQ_CLR_ADDR)
                || (wr_addr == IRQ_EN_ADDR) || (wr_addr == LSW_ADDR)
                || (wr_addr == IRQ_STAT_ADDR);
  wire rd_hit = is_buf_addr(rd_addr) || (rd_addr == FCW_ADDR) || (rd_addr == LSW_ADDR)
                || (rd_addr == IRQ_STAT_ADDR) || (rd_addr == IRQ_EN_ADDR)
                || (rd_addr == IRQ_CLR_ADDR);
  // writes to read-only words complete okay and change nothing
  assign wr_err = !wr_hit;
  assign rd_err = !rd_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // control word
  logic [FCW_W-1:0] fcw_q; // fifo_control_word
  logic [FCW_W-1:0] fcw_d;
  assign fcw_d = wr_fcw ? wr_data[FCW_W-1:0] : fcw_q;
  assign fifo_enable = fcw_q[FCW_FIFO_EN_BIT];
  assign ir_mode = fcw_q[FCW_IR_BIT];
  // toggling fifo enable discards both queues, stale bytes would otherwise mix modes
  wire fifo_flush = wr_fcw && (wr_data[FCW_FIFO_EN_BIT] != fcw_q[FCW_FIFO_EN_BIT]);

  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) fcw_q <= FCW_RST;
    else fcw_q <= fcw_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive path
  logic [BYTE_W-1:0] rx_hold_q; // rx_holding_buffer when fifos are off
  logic [BYTE_W-1:0] rx_hold_d;
  logic rx_full_q; // holding register has an unread byte
  logic rx_full_d;
  logic [BYTE_W-1:0] rxf_head;
  logic rxf_full;
  logic rxf_empty;

  // framer delivers the byte from the wire or infrared input per ir_mode
  wire rx_push_fifo = rx_valid && fifo_enable; // RULE_05
  wire rx_pop_fifo = rd_buf && fifo_enable; // RULE_05
  // overrun: holding register not yet read, or fifo already full
  // a pop in the arrival cycle makes no room, the new byte is still lost
  wire rx_hold_ovr = rx_valid && !fifo_enable && rx_full_q && !rd_buf; // RULE_04
  wire rx_fifo_ovr = rx_push_fifo && rxf_full; // RULE_06
  wire rx_ovr_evt = rx_hold_ovr || rx_fifo_ovr;

  usbp_fifo u_rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(fifo_flush),
    .push(rx_push_fifo), // RULE_06
    .push_data(rx_byte),
    .pop(rx_pop_fifo),
    .head_data(rxf_head),
    .full(rxf_full),
    .empty(rxf_empty)
  );

  // holding register: a new byte always lands, even over an unread one
  assign rx_hold_d = (rx_valid && !fifo_enable) ? rx_byte : rx_hold_q; // RULE_04
  assign rx_full_d = (rx_valid && !fifo_enable) ? 1'b1
                   : ((rd_buf && !fifo_enable) || fifo_flush) ? 1'b0 : rx_full_q;
  assign rx_byte_available_flag = fifo_enable ? !rxf_empty : rx_full_q; // RULE_03

  // receive holding state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hold_q <= BYTE_RST; // RULE_12
      rx_full_q <= 1'b0;
    end else begin
      rx_hold_q <= rx_hold_d;
      rx_full_q <= rx_full_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // line status
  logic oe_q; // overrun, held until line status is read
  logic oe_d;
  // a new overrun in the reading cycle wins over the clear
  assign oe_d = rx_ovr_evt ? 1'b1 : (rd_lsw ? 1'b0 : oe_q);
  assign overrun = oe_q;

  // overrun flag
  always_ff @(posedge aclk) begin
    if (!aresetn) oe_q <= 1'b0;
    else oe_q <= oe_d;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transmit path
  logic [BYTE_W-1:0] tx_hold_q; // tx_holding_buffer when fifos are off
  logic [BYTE_W-1:0] tx_hold_d;
  logic tx_full_q; // holding register occupied
  logic tx_full_d;
  logic [BYTE_W-1:0] txf_head;
  logic txf_full;
  logic txf_empty;

  // software is expected to wait for empty; the device still copes if it does not
  wire tx_push_fifo = wr_buf && fifo_enable && !txf_full; // RULE_08 RULE_11
  wire tx_take = tx_valid && tx_ready;

  usbp_fifo u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(fifo_flush),
    .push(tx_push_fifo), // RULE_10
    .push_data(wr_data[BYTE_W-1:0]),
    .pop(tx_take && fifo_enable),
    .head_data(txf_head),
    .full(txf_full),
    .empty(txf_empty)
  );

  // holding register: each write replaces the held byte and marks it full
  assign tx_hold_d = (wr_buf && !fifo_enable) ? wr_data[BYTE_W-1:0] : tx_hold_q; // RULE_09
  assign tx_full_d = (wr_buf && !fifo_enable) ? 1'b1
                   : ((tx_take && !fifo_enable) || fifo_flush) ? 1'b0 : tx_full_q; // RULE_09
  assign tx_holding_empty_flag = fifo_enable ? txf_empty : !tx_full_q; // RULE_09 RULE_10
  // framer routes to the wire or the inverted infrared output per ir_mode
  assign tx_valid = fifo_enable ? !txf_empty : tx_full_q; // RULE_07
  assign tx_byte = fifo_enable ? txf_head : tx_hold_q; // RULE_07

  // transmit holding state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold_q <= BYTE_RST; // RULE_12
      tx_full_q <= 1'b0;
    end else begin
      tx_hold_q <= tx_hold_d;
      tx_full_q <= tx_full_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupts
  logic [IRQ_W-1:0] irq_stat_q; // sticky events
  logic [IRQ_W-1:0] irq_stat_d;
  logic [IRQ_W-1:0] irq_en_q; // enables, same layout
  logic [IRQ_W-1:0] irq_en_d;
  logic txe_q; // previous empty flag, for the rising edge
  logic avl_q; // previous available flag
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_evt[IRQ_RX_BIT] = rx_byte_available_flag && !avl_q;
  assign irq_evt[IRQ_OE_BIT] = rx_ovr_evt;
  assign irq_evt[IRQ_TXE_BIT] = tx_holding_empty_flag && !txe_q;
  assign irq_clr = wr_irq_clr ? wr_data[IRQ_W-1:0] : '0;
  // set wins over a clear in the same cycle so no event is lost
  assign irq_stat_d = irq_evt | (irq_stat_q & ~irq_clr);
  assign irq_en_d = wr_irq_en ? wr_data[IRQ_W-1:0] : irq_en_q;
  assign irq = |(irq_stat_q & irq_en_q);

  // interrupt state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= IRQ_RST;
      irq_en_q <= IRQ_RST;
      txe_q <= 1'b1; // empty out of reset is no event
      avl_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_en_q <= irq_en_d;
      txe_q <= tx_holding_empty_flag;
      avl_q <= rx_byte_available_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux
  // buffer byte sits in 7:0, every bit above reads zero
  wire [BYTE_W-1:0] rx_head = fifo_enable ? rxf_head : rx_hold_q; // RULE_02 RULE_05
  logic [DATA_W-1:0] lsw_word; // line_status_word image

  // fields placed by their shared positions, every other bit reads zero
  always_comb begin
    lsw_word = '0;
    lsw_word[LSW_AVL_BIT] = rx_byte_available_flag; // RULE_03
    lsw_word[LSW_OE_BIT] = oe_q;
    lsw_word[LSW_TXE_BIT] = tx_holding_empty_flag;
  end

  assign rd_data = is_buf_addr(rd_addr) ? DATA_W'(rx_head) // RULE_02 RULE_12
                 : (rd_addr == LSW_ADDR) ? lsw_word
                 : (rd_addr == FCW_ADDR) ? DATA_W'(fcw_q)
                 : (rd_addr == IRQ_STAT_ADDR) ? DATA_W'(irq_stat_q)
                 : (rd_addr == IRQ_EN_ADDR) ? DATA_W'({unused_prot & 1'b0, irq_en_q})
                 : '0;

endmodule // usbp_top

// >>> hw/usbp_axil.sv
// axi4-lite slave that turns bus traffic into single-cycle strobes
module usbp_axil
  import usbp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [STRB_W-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read address and data
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  output logic wr_en,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic [STRB_W-1:0] wr_strb,
  input wire logic wr_err,
  output logic rd_en,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic rd_err
);

  logic aw_held_q; // write address captured
  logic w_held_q; // write data captured
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [STRB_W-1:0] wstrb_q;

  // one write in flight: channels close until the response is taken
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_en = aw_held_q && w_held_q;
  assign wr_addr = awaddr_q;
  assign wr_data = wdata_q;
  assign wr_strb = wstrb_q;
  // read strobe fires on the address handshake itself
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_en = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_en) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (rd_en) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_data;
      s_axi_rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule // usbp_axil

// >>> sim/usbp_props.sv
// concurrent checks on the shadow buffer port top-level pins
module usbp_props
  import usbp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  // character streams and status
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_byte_available_flag,
  input wire logic tx_holding_empty_flag,
  input wire logic overrun
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  //////////////////////////////////////////////////////////////////////////////
  // both write channels taken at one edge
  sequence s_aw_w_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // line status read clears overrun, so that window is excluded
  sequence s_lsr_quiet;
    overrun && !s_axi_rvalid && !(s_axi_arvalid && s_axi_araddr == LSW_ADDR);
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  a_write_answer: assert property (s_aw_w_take |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after handshake");
  a_read_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read data not one cycle after handshake");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_rx_flag_set: assert property (rx_valid |=> rx_byte_available_flag)
    else $error("byte arrival did not raise data ready");
  a_flag_cause: assert property ($rose(rx_byte_available_flag) |-> $past(rx_valid))
    else $error("data ready rose without arrival");
  a_overrun_cause: assert property ($rose(overrun) |-> $past(rx_valid))
    else $error("overrun rose without arrival");
  a_overrun_sticky: assert property (s_lsr_quiet |=> overrun)
    else $error("overrun dropped without status read");
  a_tx_holds: assert property (tx_valid && !tx_ready |=> tx_valid)
    else $error("queued character withdrawn");
  a_tx_not_empty: assert property ($rose(tx_holding_empty_flag) |-> $past(tx_valid && tx_ready))
    else $error("empty flag rose without a take");
endmodule // usbp_props

// >>> sim/usbp_peer.sv
// behavioural framer and deframer standing on the line side
module usbp_peer
(
  // clock and stall control from the bench
  input wire logic aclk,
  input wire logic stall,
  // characters from the device
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  // characters into the device
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got[$]; // characters sent out by the device

  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end

  // stall models a slow shifter; taken on the handshake edge only
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_byte);
    end
    tx_ready <= !stall;
  end

  // one-cycle arrival; byte inverted afterwards so stale data never looks valid
  task automatic send(input logic [7:0] b);
    @(posedge aclk);
    rx_valid <= 1'b1;
    rx_byte <= b;
    @(posedge aclk);
    rx_valid <= 1'b0;
    rx_byte <= ~b;
  endtask
endmodule // usbp_peer

// >>> sim/tb.sv
// self-checking bench for the shadow buffer port
module tb;
  import usbp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, rxv, txv, txr, stall;
  logic ir, fen, avl, txe, ovr, irq;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] rxb, txb;
  int n_mismatch = 0, comparisons = 0, cyc = 0;

  usbp_top usbp_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_valid(rxv), .rx_byte(rxb),
    .tx_valid(txv), .tx_byte(txb), .tx_ready(txr), .ir_mode(ir), .fifo_enable(fen),
    .rx_byte_available_flag(avl), .tx_holding_empty_flag(txe), .overrun(ovr), .irq(irq));
  usbp_peer usbp_peer_inst (.aclk(aclk), .stall(stall), .tx_valid(txv), .tx_byte(txb),
    .tx_ready(txr), .rx_valid(rxv), .rx_byte(rxb));

  //////////////////////////////////////////////////////////////////////////////
  // clock, and a watchdog well above the expected few hundred cycles
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // axi4-lite master: aw and w offered together, each dropped once taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid === 1'b1));
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid === 1'b1));
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk($sformatf("read %h", a), e, rd);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, aresetn} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hf;
    stall = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(BUF_ADDR, 32'h0);
    rdc(LSW_ADDR, 32'h20);
    rdc(32'h5000_1200, 32'h0);
    chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
    // holding mode: overwrite and overrun
    usbp_peer_inst.send(8'ha5);
    rdc(LSW_ADDR, 32'h21);
    rdc(BUF_ALIAS_FIRST, 32'ha5);
    usbp_peer_inst.send(8'h5a);
    usbp_peer_inst.send(8'hc3);
    rdc(IRQ_STAT_ADDR, 32'h3);
    wr(IRQ_EN_ADDR, 32'h2);
    @(negedge aclk);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(IRQ_CLR_ADDR, 32'h3);
    @(negedge aclk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    rdc(LSW_ADDR, 32'h23);
    rdc(LSW_ADDR, 32'h21);
    rdc(BUF_ALIAS_LAST, 32'hc3);
    // holding mode transmit, second write replaces the first
    stall <= 1'b1;
    wr(BUF_ADDR, 32'h0000_ab11);
    @(negedge aclk);
    chk("empty after write", 32'h0, {31'h0, txe});
    chk("tx byte", 32'h11, {24'h0, txb});
    wr(BUF_ALIAS_LAST, 32'h22);
    stall <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("sent count", 32'h1, usbp_peer_inst.got.size());
    chk("sent byte", 32'h22, {24'h0, usbp_peer_inst.got[0]});
    rdc(IRQ_STAT_ADDR, 32'h4);
    wr(IRQ_CLR_ADDR, 32'h7);
    // fifo mode receive: seventeenth byte lost
    wr(FCW_ADDR, 32'h1);
    chk("fifo enable", 32'h1, {31'h0, fen});
    for (int i = 0; i < 17; i++) usbp_peer_inst.send(8'h40 + i[7:0]);
    @(negedge aclk);
    chk("overrun pin", 32'h1, {31'h0, ovr});
    chk("data ready pin", 32'h1, {31'h0, avl});
    rdc(LSW_ADDR, 32'h23);
    for (int i = 0; i < 16; i++) rdc(BUF_ALIAS_FIRST + 4 * i, 32'h40 + i);
    rdc(LSW_ADDR, 32'h20);
    // fifo mode transmit: sixteen taken, seventeenth dropped
    usbp_peer_inst.got.delete();
    stall <= 1'b1;
    for (int i = 0; i < 17; i++) wr(BUF_ADDR, 32'h80 + i);
    stall <= 1'b0;
    repeat (30) @(posedge aclk);
    chk("fifo sent count", 32'h10, usbp_peer_inst.got.size());
    for (int i = 0; i < 16; i++) chk("fifo byte", 32'h80 + i, usbp_peer_inst.got[i]);
    // infrared mode select
    wr(FCW_ADDR, 32'h3);
    rdc(FCW_ADDR, 32'h3);
    chk("ir mode", 32'h1, {31'h0, ir});
    final_report();
  end
endmodule // tb

bind usbp_top usbp_props usbp_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .rx_valid, .tx_valid, .tx_ready, .rx_byte_available_flag,
  .tx_holding_empty_flag, .overrun);
